//--- core/cat_core_regs.svh
// Constants for the arithmetic/logic execution core: addresses, fields, resets, timing
`ifndef CAT_CORE_REGS_SVH
`define CAT_CORE_REGS_SVH
// ------------------------------------------------------------
// Address space split
// ------------------------------------------------------------
`define CAT_SFR_SEL_BIT   7
// ------------------------------------------------------------
// program_status_word field positions
// ------------------------------------------------------------
`define CAT_PSW_CY        7
`define CAT_PSW_AC        6
`define CAT_PSW_RS_HI     4
`define CAT_PSW_RS_LO     3
`define CAT_PSW_OV        2
`define CAT_PSW_P         0
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define CAT_PC_RST        16'h0000
`define CAT_ACC_RST       8'h00
`define CAT_PSW_RST       8'h00
// ------------------------------------------------------------
// Breakpoints and timing counts in clock cycles
// ------------------------------------------------------------
`define CAT_NUM_BKPT      4
`define CAT_CYC_REG       1
`define CAT_CYC_DIRECT    2
`define CAT_CYC_INDIRECT  2
`define CAT_CYC_IMMED     2
`define CAT_CYC_DIR_IMM   3
`endif

//--- core/cat_pkg.sv
// Types shared by the arithmetic/logic execution core
package cat_pkg;
    // Instruction step states, one-hot
    typedef enum logic [5:0] {
        S_FETCH = 6'b000001,
        S_OPND1 = 6'b000010,
        S_OPND2 = 6'b000100,
        S_INDIR = 6'b001000,
        S_BRTKN = 6'b010000,
        S_HALT  = 6'b100000
    } cat_state_e;

    // Operand form of an opcode
    typedef enum logic [2:0] {
        C_NOP, C_REG, C_DIR, C_IND, C_IMM, C_DIRA, C_DIRI, C_JZ
    } cat_cls_e;

    // Data memory port towards RAM and special function registers
    typedef struct packed {
        logic [7:0] raddr;
        logic       rd_sfr;
        logic       we;
        logic       wr_sfr;
        logic [7:0] waddr;
        logic [7:0] wdata;
    } cat_mem_s;

    // Debug command port behind the two-wire debug link
    typedef struct packed {
        logic             halt;
        logic             run;
        logic             step;
        logic             acc_we;
        logic             mem_we;
        logic [7:0]       addr;
        logic [7:0]       wdata;
        logic [3:0]       bp_en;
        logic [3:0][15:0] bp_addr;
    } cat_dbg_s;
endpackage

//--- core/cat_core.sv
// Arithmetic/logic execution core with cycle timing and debug run control
// Operation
// - Every instruction is timed in single clock cycles, no machine cycles.
// - Most instructions take as many cycles as they have bytes.
// - Conditional branch not taken finishes one cycle sooner than taken.
// - Opcodes, addressing modes and status flag effects match the classic set.
// - Register-with-accumulator operations are one byte, one cycle.
// - Direct byte into accumulator operations are two bytes, two cycles.
// - Indirect RAM into accumulator operations are one byte, two cycles.
// - Immediate into accumulator operations, add with carry too: two bytes, two cycles.
// - Exclusive-OR register into accumulator: one byte, one cycle.
// - Logic ops writing accumulator into direct byte: two bytes, two cycles.
// - Logic ops of immediate into direct byte: three bytes, three cycles.
// - Debug offers breakpoints, run, stop, step, register and memory access.
// - Debug uses no data memory, stack, timers or other core resources.
// - Host programs and debugs over the two-wire link the device serves.
// - Relative offsets are signed 8-bit, from the next instruction's first byte.
// - Direct addresses below 0x80 hit RAM, upper ones hit SFRs.
`timescale 1ns/10ps
`include "cat_core_regs.svh"
module cat_core
    import cat_pkg::*;
(
    input  wire logic        i_clk,        // System clock, 250 MHz
    input  wire logic        i_rst,        // Synchronous reset, active high
    input  wire logic [7:0]  i_code,       // Program byte at o_pc
    output logic      [15:0] o_pc,         // Program counter
    output cat_mem_s         o_mem,        // Data memory request
    input  wire logic [7:0]  i_ram_rdata,  // RAM byte at o_mem.raddr
    input  wire logic [7:0]  i_sfr_rdata,  // SFR byte at o_mem.raddr
    input  wire cat_dbg_s    i_dbg,        // Debug commands
    output logic      [7:0]  o_dbg_rdata,  // Debug memory read data
    output logic             o_halted,     // Core stopped for debug
    output logic      [7:0]  o_acc,        // Accumulator
    output logic      [7:0]  o_psw         // program_status_word
);
    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // Operand form from opcode; unlisted opcodes run as one-cycle no-ops
    function automatic cat_cls_e op_class(input logic [7:0] op);
        logic alu_hi;
        logic log_hi;
        alu_hi = (op[7:4] == 4'h2) || (op[7:4] == 4'h3) || (op[7:4] == 4'h9);
        log_hi = (op[7:4] == 4'h4) || (op[7:4] == 4'h5) || (op[7:4] == 4'h6);
        if (op == 8'h60 || op == 8'h70) return C_JZ;
        else if (!(alu_hi || log_hi)) return C_NOP;
        else if (op[3]) return C_REG;
        else if (op[3:1] == 3'b011) return C_IND;
        else if (op[3:0] == 4'h4) return C_IMM;
        else if (op[3:0] == 4'h5) return C_DIR;
        else if (log_hi && op[3:0] == 4'h2) return C_DIRA;
        else if (log_hi && op[3:0] == 4'h3) return C_DIRI;
        return C_NOP;
    endfunction
    // ALU: returns {cy, ac, ov, result}
    function automatic logic [10:0] alu(input logic [3:0] fn, input logic [7:0] x,
                                        input logic [7:0] y, input logic cin);
        logic [8:0] s;
        logic [4:0] h;
        logic       ov;
        s  = 9'h000;
        h  = 5'h00;
        ov = 1'b0;
        case (fn)
            4'h2, 4'h3: begin
                s  = {1'b0, x} + {1'b0, y} + {8'h00, cin};
                h  = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
                ov = (x[7] == y[7]) && (s[7] != x[7]);
            end
            4'h9: begin
                s  = {1'b0, x} - {1'b0, y} - {8'h00, cin};
                h  = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, cin};
                ov = (x[7] != y[7]) && (s[7] != x[7]);
            end
            4'h4:    s = {1'b0, x | y};
            4'h5:    s = {1'b0, x & y};
            4'h6:    s = {1'b0, x ^ y};
            default: s = {1'b0, x};
        endcase
        return {s[8], h[4], ov, s[7:0]};
    endfunction
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    cat_state_e  state_q, state_d;
    logic [15:0] pc_q, pc_d;
    logic [7:0]  acc_q, acc_d;
    logic [7:0]  psw_q, psw_d;
    logic [7:0]  opc_q;
    logic [7:0]  adr_q;
    logic [1:0]  step_q, step_d;
    // ------------------------------------------------------------
    // Combinational decode and datapath
    // ------------------------------------------------------------
    wire        st_fetch = (state_q == S_FETCH);
    wire        st_op1   = (state_q == S_OPND1);
    wire        st_op2   = (state_q == S_OPND2);
    wire        st_ind   = (state_q == S_INDIR);
    wire        st_halt  = (state_q == S_HALT);
    wire [7:0]  cur_op   = st_fetch ? i_code : opc_q;
    cat_cls_e   cls;
    assign cls = op_class(cur_op);
    wire [1:0]  bank     = psw_q[`CAT_PSW_RS_HI:`CAT_PSW_RS_LO];
    wire [2:0]  reg_idx  = (cls == C_IND) ? {2'b00, i_code[0]} : i_code[2:0];
    // Breakpoint compare on the fetch address, no core resources used
    wire [3:0]  bp_hit_v;
    genvar gi;
    for (gi = 0; gi < `CAT_NUM_BKPT; gi++) begin : g_bp
        assign bp_hit_v[gi] = i_dbg.bp_en[gi] && (i_dbg.bp_addr[gi] == pc_q);
    end
    // A fresh step skips its own breakpoint; an armed step stops at the next boundary
    wire halt_go = st_fetch && ((step_q == 2'd1) ||
                   ((i_dbg.halt || (|bp_hit_v)) && step_q != 2'd2));
    // Read address: bank register, direct byte, latched address or debug
    wire [7:0] raddr = st_halt                    ? i_dbg.addr :
                       st_fetch                   ? {3'b000, bank, reg_idx} :
                       (st_op1 && cls != C_DIRI)  ? i_code : adr_q;
    // Indirect reads always land in RAM
    wire       rd_sfr = raddr[`CAT_SFR_SEL_BIT] && !st_ind;
    wire [7:0] rdata  = rd_sfr ? i_sfr_rdata : i_ram_rdata;
    // Operands: destination-in-memory forms use the memory byte as x
    wire       dst_mem = (cls == C_DIRA) || (cls == C_DIRI);
    wire [7:0] alu_x   = dst_mem ? rdata : acc_q;
    wire [7:0] alu_y   = (cls == C_DIRA)                    ? acc_q  :
                         (cls == C_DIRI || cls == C_IMM)     ? i_code : rdata;
    wire       cin     = (cur_op[7:4] != 4'h2) && psw_q[`CAT_PSW_CY];
    wire [10:0] alu_r  = alu(cur_op[7:4], alu_x, alu_y, cin);
    wire       arith   = (cur_op[7:4] inside {4'h2, 4'h3, 4'h9});
    // Final cycle of each form, where the result is committed
    wire exec = (st_fetch && !halt_go && cls == C_REG) ||
                (st_op1 && (cls == C_DIR || cls == C_IMM || cls == C_DIRA)) ||
                (st_op2 && cls == C_DIRI) ||
                st_ind;
    // Branch on accumulator zero; offset is signed from next instruction
    wire        br_take = (opc_q[4] == 1'b0) ? (acc_q == 8'h00) : (acc_q != 8'h00);
    wire [15:0] br_tgt  = pc_q + 16'h0001 + {{8{i_code[7]}}, i_code};
    // ------------------------------------------------------------
    // Next state, one step per clock
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        pc_d    = pc_q;
        step_d  = step_q;
        case (state_q)
            S_FETCH: begin
                if (halt_go) begin
                    state_d = S_HALT;
                    step_d  = 2'd0;
                end else begin
                    pc_d = pc_q + 16'h0001;
                    if (step_q == 2'd2)
                        step_d = 2'd1;
                    case (cls)
                        C_REG, C_NOP: state_d = S_FETCH;
                        C_IND:        state_d = S_INDIR;
                        default:      state_d = S_OPND1;
                    endcase
                end
            end
            S_OPND1: begin
                pc_d    = pc_q + 16'h0001;
                state_d = (cls == C_DIRI) ? S_OPND2 : S_FETCH;
                if (cls == C_JZ && br_take) begin
                    pc_d    = br_tgt;
                    state_d = S_BRTKN;
                end
            end
            S_OPND2: begin
                pc_d    = pc_q + 16'h0001;
                state_d = S_FETCH;
            end
            S_INDIR, S_BRTKN: state_d = S_FETCH;
            S_HALT: begin
                if (i_dbg.step) begin
                    state_d = S_FETCH;
                    step_d  = 2'd2;
                end else if (i_dbg.run) begin
                    state_d = S_FETCH;
                end
            end
            default: state_d = S_FETCH;
        endcase
    end
    // Accumulator and flag update; debug may load the accumulator when stopped
    always_comb begin
        acc_d = acc_q;
        psw_d = psw_q;
        if (exec && !dst_mem)
            acc_d = alu_r[7:0];
        if (exec && arith) begin
            psw_d[`CAT_PSW_CY] = alu_r[10];
            psw_d[`CAT_PSW_AC] = alu_r[9];
            psw_d[`CAT_PSW_OV] = alu_r[8];
        end
        if (st_halt && i_dbg.acc_we)
            acc_d = i_dbg.wdata;
        psw_d[`CAT_PSW_P] = ^acc_d;
    end
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Single-clock timing: each state except S_HALT holds exactly one cycle
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q <= S_FETCH;
            pc_q    <= `CAT_PC_RST;
            acc_q   <= `CAT_ACC_RST;
            psw_q   <= `CAT_PSW_RST;
            step_q  <= 2'd0;
        end else begin
            state_q <= state_d;
            pc_q    <= pc_d;
            acc_q   <= acc_d;
            psw_q   <= psw_d;
            step_q  <= step_d;
        end
    end
    // Opcode latch and pointer / direct address latch
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            opc_q <= 8'h00;
            adr_q <= 8'h00;
        end else begin
            if (st_fetch) opc_q <= i_code;
            if (st_fetch && cls == C_IND) adr_q <= rdata;
            else if (st_op1 && cls == C_DIRI) adr_q <= i_code;
        end
    end
    // ------------------------------------------------------------
    // Outputs; write strobes are combinational so a result lands in its own cycle
    // ------------------------------------------------------------
    wire dbg_wr = st_halt && i_dbg.mem_we;
    wire [7:0] waddr = dbg_wr ? i_dbg.addr : (st_op1 ? i_code : adr_q);
    assign o_mem.raddr  = raddr;
    assign o_mem.rd_sfr = rd_sfr;
    assign o_mem.we     = (exec && dst_mem) || dbg_wr;
    assign o_mem.waddr  = waddr;
    assign o_mem.wr_sfr = waddr[`CAT_SFR_SEL_BIT];
    assign o_mem.wdata  = dbg_wr ? i_dbg.wdata : alu_r[7:0];
    assign o_dbg_rdata  = rdata;
    assign o_pc         = pc_q;
    assign o_acc        = acc_q;
    assign o_psw        = psw_q;
    assign o_halted     = st_halt;
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb_core @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    wire go = st_fetch && !halt_go;
    sequence s_two;
        ##1 (state_q == S_OPND1) ##1 (state_q == S_FETCH || state_q == S_HALT);
    endsequence
    property p_onehot;
        $onehot(state_q);
    endproperty
    a_onehot: assert property (p_onehot) else $error("state not one-hot");
    property p_reg_one;
        go && cls == C_REG |=> st_fetch && pc_q == $past(pc_q) + 16'h0001;
    endproperty
    a_reg_one: assert property (p_reg_one) else $error("register op not 1 cycle");
    property p_xrl_reg;
        go && cls == C_REG && i_code[7:4] == 4'h6 |=> acc_q == ($past(acc_q) ^ $past(rdata));
    endproperty
    a_xrl_reg: assert property (p_xrl_reg) else $error("register xor wrong");
    property p_dir_two;
        go && (cls == C_DIR || cls == C_DIRA) |-> s_two;
    endproperty
    a_dir_two: assert property (p_dir_two) else $error("direct op not 2 cycles");
    property p_ind_two;
        go && cls == C_IND |=> st_ind ##1 pc_q == $past(pc_q, 2) + 16'h0001;
    endproperty
    a_ind_two: assert property (p_ind_two) else $error("indirect op timing");
    property p_imm_two;
        go && cls == C_IMM |-> s_two ##0 pc_q == $past(pc_q, 2) + 16'h0002;
    endproperty
    a_imm_two: assert property (p_imm_two) else $error("immediate op timing");
    property p_dira_wr;
        go && cls == C_DIRA |=> o_mem.we && o_mem.waddr == i_code;
    endproperty
    a_dira_wr: assert property (p_dira_wr) else $error("direct,A write missing");
    property p_diri_three;
        go && cls == C_DIRI |=> st_op1 ##1 (st_op2 && o_mem.we) ##1 !st_op2;
    endproperty
    a_diri_three: assert property (p_diri_three) else $error("direct,#imm timing");
    property p_br_time;
        st_op1 && cls == C_JZ |-> (br_take ##1 state_q == S_BRTKN ##1 st_fetch || st_halt)
                                 or (!br_take ##1 st_fetch || st_halt);
    endproperty
    a_br_time: assert property (p_br_time) else $error("branch timing");
    property p_sfr_sel;
        st_op1 && cls == C_DIR |-> o_mem.rd_sfr == i_code[7];
    endproperty
    a_sfr_sel: assert property (p_sfr_sel) else $error("SFR select wrong");
endmodule

//--- testbench/cat_mem_model.sv
// Partner model: program memory and data memory facing the core
`timescale 1ns/10ps
module cat_mem_model
    import cat_pkg::*;
(
    input  wire logic        i_clk,        // System clock
    input  wire logic [15:0] i_pc,         // Fetch address
    output logic      [7:0]  o_code,       // Program byte
    input  wire cat_mem_s    i_mem,        // Data memory request
    output logic      [7:0]  o_ram_rdata,  // Lower RAM read data
    output logic      [7:0]  o_sfr_rdata   // SFR read data
);
    logic [7:0] code [256];
    logic [7:0] mem  [256];
    // ------------------------------------------------------------
    // Reads
    // ------------------------------------------------------------
    // Asynchronous; fetches past the loaded page return junk
    assign o_code      = (i_pc[15:8] == 8'h00) ? code[i_pc[7:0]] : ~i_pc[7:0];
    assign o_ram_rdata = mem[{1'b0, i_mem.raddr[6:0]}];
    assign o_sfr_rdata = mem[{1'b1, i_mem.raddr[6:0]}];
    // Write lands on the edge where the strobe is high
    always @(posedge i_clk) begin
        if (i_mem.we === 1'b1) begin
            mem[{i_mem.wr_sfr, i_mem.waddr[6:0]}] <= i_mem.wdata;
        end
    end
endmodule

//--- testbench/core_arith_logic_timing_tb_top.sv
// Self-checking bench for the arithmetic/logic execution core
`timescale 1ns/10ps
module core_arith_logic_timing_tb_top;
    import cat_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [15:0] o_pc;
    cat_mem_s    o_mem;
    logic [7:0]  code, ram_rd, sfr_rd, o_dbg_rdata, o_acc, o_psw, racc, rpsw;
    logic        o_halted;
    cat_dbg_s    dbg = '0;
    logic [7:0]  prog [256];
    logic [7:0]  rram [256];
    int          plen, failures = 0, tests_run = 0;

    always #2 i_clk = ~i_clk;

    cat_core cat_core_i (.i_clk(i_clk), .i_rst(i_rst), .i_code(code), .o_pc(o_pc),
        .o_mem(o_mem), .i_ram_rdata(ram_rd), .i_sfr_rdata(sfr_rd), .i_dbg(dbg),
        .o_dbg_rdata(o_dbg_rdata), .o_halted(o_halted), .o_acc(o_acc), .o_psw(o_psw));
    cat_mem_model cat_mem_model_i (.i_clk(i_clk), .i_pc(o_pc), .o_code(code), .i_mem(o_mem),
        .o_ram_rdata(ram_rd), .o_sfr_rdata(sfr_rd));

    // ------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic wait_halt(input logic lvl);
        int k;
        k = 0;
        while (o_halted !== lvl) begin
            @(negedge i_clk);
            k++;
            if (k > 40) begin
                failures++;
                $display("[FAIL] %0t halt wait timed out", $time);
                finish_test();
            end
        end
    endtask

    // ------------------------------------------------------------
    // Reference instruction model
    // ------------------------------------------------------------
    function automatic logic [7:0] lop(input logic [3:0] g, input logic [7:0] a, b);
        return (g == 4'h4) ? (a | b) : (g == 4'h5) ? (a & b) : (a ^ b);
    endfunction

    task automatic ref_run(output int cyc);
        int         pc;
        logic [3:0] g, f;
        logic [7:0] b1, b2, v, ci;
        logic [8:0] s;
        pc = 0;
        cyc = 0;
        racc = 8'h00;
        rpsw = 8'h00;
        while (pc < plen) begin
            g = prog[pc][7:4];
            f = prog[pc][3:0];
            b1 = prog[pc+1];
            b2 = prog[pc+2];
            if (f == 4'h0) begin
                // Not taken costs one cycle less; offset from next opcode
                pc += 2;
                cyc += 2;
                if ((racc == 8'h00) == (g == 4'h6)) begin
                    pc += int'($signed(b1));
                    cyc += 1;
                end
            end else if (f < 4'h4) begin
                rram[b1] = lop(g, rram[b1], (f == 4'h2) ? racc : b2);
                pc += int'(f);
                cyc += int'(f);
            end else begin
                // Indirect pointer only reaches the lower RAM
                if (f >= 4'h8) v = rram[{3'b000, rpsw[4:3], f[2:0]}];
                else if (f == 4'h4) v = b1;
                else if (f == 4'h5) v = rram[b1];
                else v = rram[{1'b0, rram[{3'b000, rpsw[4:3], 2'b00, f[0]}][6:0]}];
                pc += (f == 4'h4 || f == 4'h5) ? 2 : 1;
                cyc += (f >= 4'h8) ? 1 : 2;
                ci = (g == 4'h2) ? 8'h00 : {7'h00, rpsw[7]};
                if (g == 4'h9) begin
                    s = {1'b0, racc} - v - ci;
                    rpsw[6] = {1'b0, racc[3:0]} < {1'b0, v[3:0]} + ci[4:0];
                    rpsw[2] = (racc[7] != v[7]) && (s[7] != racc[7]);
                end else if (g < 4'h4) begin
                    s = racc + v + ci;
                    rpsw[6] = {1'b0, racc[3:0]} + {1'b0, v[3:0]} + ci[4:0] > 5'h0f;
                    rpsw[2] = (racc[7] == v[7]) && (s[7] != racc[7]);
                end else s = {rpsw[7], lop(g, racc, v)};
                rpsw[7] = s[8];
                racc = s[7:0];
            end
        end
        rpsw[0] = ^racc;
    endtask

    // ------------------------------------------------------------
    // Program building and running
    // ------------------------------------------------------------
    task automatic add_ins(input logic [3:0] g, input logic [3:0] f);
        logic [7:0] d;
        d = 8'($urandom);
        // Keep accumulator and status word out of direct reach
        if (d == 8'hd0 || d == 8'he0) d = d ^ 8'h01;
        prog[plen] = {g, f};
        prog[plen+1] = d;
        prog[plen+2] = 8'($urandom);
        plen += (f == 4'h3) ? 3 : (f inside {4'h2, 4'h4, 4'h5}) ? 2 : 1;
    endtask

    task automatic load_prog();
        for (int k = 0; k < 256; k++) begin
            rram[k] = (k < 2) ? 8'($urandom_range(0, 127)) : 8'($urandom);
            cat_mem_model_i.code[k] = (k < plen) ? prog[k] : 8'h00;
            cat_mem_model_i.mem[k] = rram[k];
        end
    endtask

    task automatic run_prog(input string what);
        int cyc, cnt;
        load_prog();
        ref_run(cyc);
        i_rst = 1'b1;
        repeat (2) @(negedge i_clk);
        i_rst = 1'b0;
        cnt = 0;
        while (o_pc !== 16'(plen + 1) && cnt < 400) begin
            @(negedge i_clk);
            cnt++;
        end
        chk(16'(cnt), 16'(cyc + 1), what);
        chk({o_acc, o_psw}, {racc, rpsw}, what);
        cnt = 0;
        for (int k = 0; k < 256; k++) begin
            if (cat_mem_model_i.mem[k] !== rram[k]) cnt++;
        end
        chk(16'(cnt), 16'h0000, what);
        if (failures > 0) finish_test();
    endtask

    task automatic prog4(input logic [31:0] w, input string what);
        plen = 4;
        for (int k = 0; k < 4; k++) prog[k] = w[31-8*k -: 8];
        run_prog(what);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [3:0]  grp [6];
        logic [3:0]  f, g;
        logic [15:0] pcs;
        int          seed;
        grp = '{4'h2, 4'h3, 4'h9, 4'h4, 4'h5, 4'h6};
        seed = $urandom(9);
        repeat (10) @(negedge i_clk);
        chk({o_pc[7:0], o_acc}, 16'h0000, "reset");
        chk({o_psw, 7'h00, o_halted}, 16'h0000, "reset");
        // Every operation group in every operand form, alone
        foreach (grp[i]) begin
            for (int j = 2; j < 16; j++) begin
                if (i > 2 || j > 3) begin
                    plen = 0;
                    add_ins(grp[i], 4'(j));
                    run_prog("form");
                end
            end
        end
        prog4(32'h60022401, "branch zero");
        prog4(32'h70022401, "branch nonzero");
        prog4(32'h244070fc, "backward loop");
        repeat (30) begin
            plen = 0;
            repeat (10) begin
                g = grp[$urandom_range(0, 5)];
                f = 4'($urandom_range(2, 15));
                if (f < 4'h4 && g < 4'ha) f = f + 4'h4;
                add_ins(g, f);
            end
            run_prog("random");
        end
        // Breakpoint, debug writes, step, run and halt
        plen = 8;
        for (int k = 0; k < 8; k++) prog[k] = 8'h28;
        load_prog();
        cat_mem_model_i.mem[0] = 8'h01;
        dbg.bp_en = 4'h1;
        dbg.bp_addr[0] = 16'h0003;
        i_rst = 1'b1;
        @(negedge i_clk);
        i_rst = 1'b0;
        wait_halt(1'b1);
        chk({o_pc[7:0], o_acc}, 16'h0303, "breakpoint");
        dbg.acc_we = 1'b1;
        dbg.wdata = 8'h40;
        @(negedge i_clk);
        dbg.acc_we = 1'b0;
        chk({8'h00, o_acc}, 16'h0040, "debug acc");
        dbg.mem_we = 1'b1;
        dbg.addr = 8'h10;
        dbg.wdata = 8'ha5;
        @(negedge i_clk);
        dbg.mem_we = 1'b0;
        chk({o_dbg_rdata, cat_mem_model_i.mem[16]}, 16'ha5a5, "debug mem");
        dbg.step = 1'b1;
        @(negedge i_clk);
        dbg.step = 1'b0;
        wait_halt(1'b1);
        chk({o_pc[7:0], o_acc}, 16'h0441, "step");
        dbg.bp_en = 4'h0;
        dbg.run = 1'b1;
        @(negedge i_clk);
        dbg.run = 1'b0;
        chk(16'(o_halted), 16'h0000, "run");
        // Memory write while running must be ignored
        dbg.mem_we = 1'b1;
        dbg.addr = 8'h11;
        dbg.wdata = ~rram[17];
        @(negedge i_clk);
        dbg.mem_we = 1'b0;
        chk({8'h00, cat_mem_model_i.mem[17]}, {8'h00, rram[17]}, "refused");
        dbg.halt = 1'b1;
        wait_halt(1'b1);
        pcs = o_pc;
        repeat (3) @(negedge i_clk);
        chk(o_pc, pcs, "halt hold");
        dbg.halt = 1'b0;
        finish_test();
    end
endmodule
